// File: inc/bcu_pkg.sv
package bcu_pkg;
    // ------------------------------------------------------------
    // register select and command codes
    // ------------------------------------------------------------
    localparam logic       REG_DATA   = 1'b0;
    localparam logic       REG_CMD    = 1'b1;
    localparam logic [7:0] OP_KEY     = 8'h40;
    localparam logic [7:0] OP_ENC     = 8'h30;
    localparam logic [7:0] OP_DEC     = 8'h20;
    localparam logic [3:0] OP_MODE_HI = 4'h0;
    localparam int         OP_PORT_B  = 7;

    // ------------------------------------------------------------
    // set-mode enable bit positions
    // ------------------------------------------------------------
    localparam int MODE_OAV  = 3;
    localparam int MODE_SRQ  = 2;
    localparam int MODE_DMA  = 1;
    localparam int MODE_CONVERSION_COMPLETE = 0;

    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int ST_KPE = 4;
    localparam int ST_CF  = 3;
    localparam int ST_DEC = 2;
    localparam int ST_IBF = 1;
    localparam int ST_OBF = 0;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [6:0] PORT_RESET  = 7'h7f;
    localparam logic [3:0] MODE_RESET  = 4'h0;
    localparam int         BLK_BYTES   = 8;
    localparam logic [3:0] SYNC_DIV    = 4'hf;
    localparam int         CONV_CYCLES = 16;

    typedef enum logic [2:0] {
        BCU_IDLE = 3'b000,
        BCU_KEY  = 3'b001,
        BCU_CNT  = 3'b010,
        BCU_CONV = 3'b011,
        BCU_DOUT = 3'b100
    } bcu_state_t;
endpackage

// File: inc/bcu_bus_if.sv
`timescale 1ns/100ps
interface bcu_bus_if;
    logic       wr_stb;
    logic       rd_stb;
    logic       rd_act;
    logic       sel;
    logic [7:0] wdata;
    modport front (output wr_stb, rd_stb, rd_act, sel, wdata);
    modport core  (input  wr_stb, rd_stb, rd_act, sel, wdata);
endinterface

// File: design/bcu_front.sv
`timescale 1ns/100ps
module bcu_front (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       register_select,
    input  wire logic       dma_acknowledge_n,
    input  wire logic [7:0] d_in,
    bcu_bus_if.front        bus
);
    logic [12:0] pin_s1;
    logic [12:0] pin_s2;
    logic        act;
    logic        wr_low;
    logic        rd_low;
    logic        wr_q;
    logic        rd_q;

    // ------------------------------------------------------------
    // two-stage pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        pin_s1 <= {cs_n, rd_n, wr_n, register_select, dma_acknowledge_n, d_in};
        pin_s2 <= pin_s1;
    end

    // select or dma acknowledge opens the strobes
    assign act    = !pin_s2[12] || !pin_s2[8]; // see RQ24
    assign wr_low = act && !pin_s2[10];
    assign rd_low = act && !pin_s2[11];

    // ------------------------------------------------------------
    // strobe end detection, data and address capture
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_q       <= 1'b0;
            rd_q       <= 1'b0;
            bus.wr_stb <= 1'b0;
            bus.rd_stb <= 1'b0;
            bus.rd_act <= 1'b0;
            bus.sel    <= bcu_pkg::REG_DATA;
            bus.wdata  <= 8'h00;
        end else begin
            wr_q       <= wr_low;
            rd_q       <= rd_low;
            bus.wr_stb <= wr_q && !wr_low;
            bus.rd_stb <= rd_q && !rd_low;
            bus.rd_act <= rd_low;
            if (wr_low) begin
                bus.wdata <= pin_s2[7:0];
            end
            // dma cycles always reach the data register
            if (wr_low || rd_low) begin
                bus.sel <= pin_s2[8] ? pin_s2[9] : bcu_pkg::REG_DATA; // see RQ1
            end
        end
    end
endmodule

// File: design/bcu_top.sv
`timescale 1ns/100ps
// Functional notes
// RQ1: address line picks data or command/status; nothing happens while deselected.
// RQ2: data bytes are key, block data or dma count by preceding command.
// RQ3: status reads key error, completion, decrypt, input full, output full.
// RQ4: output full set when converted byte waits, cleared by its read.
// RQ5: any host write sets input full; cleared once the byte is taken.
// RQ6: host must not write while input full is one.
// RQ7: decrypt status bit is one in decrypt mode, zero in encrypt.
// RQ8: completion marks block end, key check validity and dma end.
// RQ9: after key entry, parity result reported, qualified by completion.
// RQ10: enter-key takes eight odd-parity bytes into the key store.
// RQ11: encrypt command selects encrypt mode, keeps key and enables.
// RQ12: distinct decrypt command selects decrypt mode, keeps key and enables.
// RQ13: set-mode low nibble enables output available, service, dma, complete.
// RQ14: set-mode with dma bit takes next data byte as block count.
// RQ15: host should enable output available and service along with dma.
// RQ16: top-bit command latches seven bits to user port; resets all ones.
// RQ17: service request, if enabled, shows waiting for input; implies not full.
// RQ18: output available, if enabled, shows waiting output; implies output full.
// RQ19: conversion complete, if enabled, asserts when a block has converted; in dma mode the code asserts it only after the last block is read.
// RQ20: sync output pulses at core clock divided by fifteen.
// RQ21: dma request asks for a cycle; acknowledge answers active low.
// RQ22: reset returns the unit to its initial state.
// RQ23: host writes eight bytes, reads eight back; commands between blocks.
// RQ24: chip select active low gates both strobes.
module bcu_top #(
    parameter int CONV_CYCLES = bcu_pkg::CONV_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       register_select,
    input  wire logic       dma_acknowledge_n,
    input  wire logic [7:0] d_in,
    output logic      [7:0] d_out,
    output logic            d_oe,
    output logic            service_request,
    output logic            output_available,
    output logic            conversion_complete,
    output logic            dma_request,
    output logic      [6:0] user_output_port,
    output logic            sync_out
);
    localparam int CW = $clog2(CONV_CYCLES + 1);

    bcu_bus_if bus ();

    bcu_pkg::bcu_state_t state;
    logic [7:0]  in_byte;
    logic        in_cmd;
    logic        input_full;
    logic        output_full;
    logic        completion_flag;
    logic        key_parity_error;
    logic        decrypt_mode_flag;
    logic        conv_done;
    logic [3:0]  mode_en;
    logic        dma_active;
    logic [7:0]  blocks_left;
    logic [2:0]  idx;
    logic [7:0]  key_mem [bcu_pkg::BLK_BYTES];
    logic [7:0]  key_new [bcu_pkg::BLK_BYTES];
    logic [7:0]  blk     [bcu_pkg::BLK_BYTES];
    logic        parity_bad;
    logic        kchk;
    logic [7:0]  out_byte;
    logic [CW-1:0] conv_cnt;
    logic [3:0]  sync_cnt;
    logic        take;
    logic        cmd_take;
    logic        data_take;
    logic        rd_data;
    logic        load_req;
    logic        last_rd;
    logic        dma_fin;
    logic        awaiting;
    logic        next_input_full;
    logic        next_output_full;
    logic        next_conv_done;
    logic [7:0]  status;

    // set-mode commands carry a zero upper nibble
    function automatic logic is_mode(input logic [7:0] b);
        return b[7:4] == bcu_pkg::OP_MODE_HI;
    endfunction

    // stand-in for the omitted cipher core, reversible per byte
    function automatic logic [7:0] convert(input logic [7:0] d, input logic [7:0] k);
        return d ^ k;
    endfunction

    // ------------------------------------------------------------
    // host bus front end
    // ------------------------------------------------------------
    bcu_front u_front (
        .core_clk          (core_clk),
        .srst              (srst),
        .cs_n              (cs_n),
        .rd_n              (rd_n),
        .wr_n              (wr_n),
        .register_select   (register_select),
        .dma_acknowledge_n (dma_acknowledge_n),
        .d_in              (d_in),
        .bus               (bus.front)
    );

    // ------------------------------------------------------------
    // decode of accepted bytes and handshake terms
    // ------------------------------------------------------------
    assign take      = input_full && state != bcu_pkg::BCU_CONV;
    assign cmd_take  = take && in_cmd;
    assign data_take = take && !in_cmd;
    assign rd_data   = bus.rd_stb && bus.sel == bcu_pkg::REG_DATA;
    assign load_req  = state == bcu_pkg::BCU_DOUT && !output_full;
    assign last_rd   = state == bcu_pkg::BCU_DOUT && rd_data && output_full && idx == 3'd7;
    assign dma_fin   = last_rd && dma_active && blocks_left == 8'h01;
    assign awaiting  = state inside {bcu_pkg::BCU_IDLE, bcu_pkg::BCU_KEY, bcu_pkg::BCU_CNT};

    // write sets input full ahead of the take clearing it
    assign next_input_full  = bus.wr_stb ? 1'b1 : (take ? 1'b0 : input_full); // see RQ5
    assign next_output_full = load_req ? 1'b1 : (rd_data ? 1'b0 : output_full); // see RQ4
    assign next_conv_done   = ((load_req && idx == 3'd0 && !dma_active) || dma_fin) ? 1'b1 :
                              (((rd_data && !dma_active) || bus.wr_stb) ? 1'b0 : conv_done);

    // status byte, upper bits read zero
    always_comb begin
        status                 = 8'h00;
        status[bcu_pkg::ST_KPE] = key_parity_error;
        status[bcu_pkg::ST_CF]  = completion_flag;
        status[bcu_pkg::ST_DEC] = decrypt_mode_flag;
        status[bcu_pkg::ST_IBF] = input_full;
        status[bcu_pkg::ST_OBF] = output_full; // see RQ3
    end

    // ------------------------------------------------------------
    // input holding register and full flag
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            input_full <= 1'b0;
            in_byte    <= 8'h00;
            in_cmd     <= 1'b0;
        end else begin
            input_full <= next_input_full;
            if (bus.wr_stb) begin
                in_byte <= bus.wdata;
                in_cmd  <= bus.sel;
            end
        end
    end

    // ------------------------------------------------------------
    // output buffer and its full flag
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            output_full <= 1'b0;
            out_byte    <= 8'h00;
            conv_done   <= 1'b0;
        end else begin
            output_full <= next_output_full;
            conv_done   <= next_conv_done; // see RQ19
            if (load_req) begin
                out_byte <= convert(blk[idx], key_mem[idx]);
            end
        end
    end

    // ------------------------------------------------------------
    // mode, enables and user port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin // see RQ22
            mode_en           <= bcu_pkg::MODE_RESET;
            decrypt_mode_flag <= 1'b0;
            user_output_port  <= bcu_pkg::PORT_RESET;
        end else if (cmd_take) begin
            if (in_byte[bcu_pkg::OP_PORT_B]) begin
                user_output_port <= in_byte[6:0]; // see RQ16
            end else if (in_byte == bcu_pkg::OP_ENC) begin
                decrypt_mode_flag <= 1'b0; // see RQ11
            end else if (in_byte == bcu_pkg::OP_DEC) begin
                decrypt_mode_flag <= 1'b1; // see RQ12 see RQ7
            end else if (is_mode(in_byte)) begin
                mode_en <= in_byte[3:0]; // see RQ13
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer: key entry, block input, conversion, readout
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state            <= bcu_pkg::BCU_IDLE;
            idx              <= 3'd0;
            completion_flag  <= 1'b0;
            key_parity_error <= 1'b0;
            parity_bad       <= 1'b0;
            kchk             <= 1'b0;
            conv_cnt         <= '0;
            dma_active       <= 1'b0;
            blocks_left      <= 8'h00;
        end else begin
            kchk <= 1'b0;
            // key result valid one cycle after completion rises
            if (kchk) begin
                key_parity_error <= parity_bad; // see RQ9
                completion_flag  <= 1'b0; // see RQ8
            end
            if (cmd_take && !in_byte[bcu_pkg::OP_PORT_B]) begin
                idx             <= 3'd0;
                completion_flag <= 1'b0;
                state           <= bcu_pkg::BCU_IDLE;
                if (in_byte == bcu_pkg::OP_KEY) begin
                    state      <= bcu_pkg::BCU_KEY;
                    parity_bad <= 1'b0;
                end else if (is_mode(in_byte) && in_byte[bcu_pkg::MODE_DMA]) begin
                    state <= bcu_pkg::BCU_CNT;
                end
            end else if (data_take && state != bcu_pkg::BCU_DOUT) begin // see RQ2
                unique case (state)
                    bcu_pkg::BCU_KEY: begin
                        key_new[idx] <= in_byte; // see RQ10
                        if (!(^in_byte)) begin
                            parity_bad <= 1'b1;
                        end
                        idx <= idx + 3'd1;
                        if (idx == 3'd7) begin
                            completion_flag <= 1'b1;
                            kchk            <= 1'b1;
                            state           <= bcu_pkg::BCU_IDLE;
                        end
                    end
                    bcu_pkg::BCU_CNT: begin
                        blocks_left <= in_byte; // see RQ14
                        dma_active  <= in_byte != 8'h00;
                        state       <= bcu_pkg::BCU_IDLE;
                    end
                    bcu_pkg::BCU_IDLE: begin
                        blk[idx] <= in_byte; // see RQ23
                        idx      <= idx + 3'd1;
                        if (idx == 3'd0) begin
                            completion_flag <= 1'b0;
                        end
                        if (idx == 3'd7) begin
                            completion_flag <= 1'b1;
                            conv_cnt        <= '0;
                            state           <= bcu_pkg::BCU_CONV;
                        end
                    end
                    default: begin
                        // bytes written during readout are dropped
                    end
                endcase
            end else if (state == bcu_pkg::BCU_CONV) begin
                conv_cnt <= conv_cnt + CW'(1);
                if (conv_cnt == CW'(CONV_CYCLES - 1)) begin
                    idx   <= 3'd0;
                    state <= bcu_pkg::BCU_DOUT;
                end
            end else if (state == bcu_pkg::BCU_DOUT && rd_data && output_full) begin
                idx <= idx + 3'd1;
                if (last_rd) begin
                    state           <= bcu_pkg::BCU_IDLE;
                    completion_flag <= 1'b0;
                    if (dma_active) begin
                        blocks_left <= blocks_left - 8'h01;
                        if (dma_fin) begin
                            dma_active      <= 1'b0;
                            completion_flag <= 1'b1; // see RQ8
                        end
                    end
                end
            end
        end
    end

    // commit the new key only when every byte had odd parity
    always_ff @(posedge core_clk) begin
        if (kchk && !parity_bad) begin
            key_mem <= key_new; // see RQ10
        end
    end

    // ------------------------------------------------------------
    // host read data and request outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            d_out               <= 8'h00;
            d_oe                <= 1'b0;
            service_request     <= 1'b0;
            output_available    <= 1'b0;
            conversion_complete <= 1'b0;
            dma_request         <= 1'b0;
        end else begin
            d_oe                <= bus.rd_act; // see RQ24
            d_out               <= bus.sel ? status : out_byte; // see RQ1
            service_request     <= mode_en[bcu_pkg::MODE_SRQ] && awaiting && !next_input_full; // see RQ17
            output_available    <= mode_en[bcu_pkg::MODE_OAV] && next_output_full; // see RQ18
            conversion_complete <= mode_en[bcu_pkg::MODE_CONVERSION_COMPLETE] && next_conv_done;
            dma_request         <= dma_active && mode_en[bcu_pkg::MODE_DMA] &&
                                   ((awaiting && !next_input_full) || next_output_full); // see RQ21
        end
    end

    // ------------------------------------------------------------
    // sync strobe divider
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync_cnt <= 4'h0;
            sync_out <= 1'b0;
        end else begin
            sync_cnt <= (sync_cnt == bcu_pkg::SYNC_DIV - 4'h1) ? 4'h0 : sync_cnt + 4'h1;
            sync_out <= sync_cnt == bcu_pkg::SYNC_DIV - 4'h1; // see RQ20
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_key_last;
        data_take && state == bcu_pkg::BCU_KEY && idx == 3'd7;
    endsequence
    sequence s_key_report;
        completion_flag ##1 !completion_flag;
    endsequence

    property p_ifull_set;
        bus.wr_stb |=> input_full;
    endproperty
    a_ifull_set: assert property (p_ifull_set) else $error("write did not set input full"); // see RQ5

    property p_ifull_clr;
        take && !bus.wr_stb |=> !input_full;
    endproperty
    a_ifull_clr: assert property (p_ifull_clr) else $error("taken byte left input full"); // see RQ5

    property p_ofull_clr;
        rd_data && output_full && !load_req |=> !output_full ##1 (output_full || state != bcu_pkg::BCU_DOUT);
    endproperty
    a_ofull_clr: assert property (p_ofull_clr) else $error("output full not cleared then reloaded"); // see RQ4

    property p_srq;
        service_request |-> !input_full;
    endproperty
    a_srq: assert property (p_srq) else $error("service request while input full"); // see RQ17

    property p_oav;
        output_available |-> output_full;
    endproperty
    a_oav: assert property (p_oav) else $error("output available without output full"); // see RQ18

    property p_dec;
        cmd_take && in_byte == bcu_pkg::OP_DEC |=> decrypt_mode_flag && $stable(mode_en);
    endproperty
    a_dec: assert property (p_dec) else $error("decrypt command not honoured"); // see RQ12

    property p_port;
        cmd_take && in_byte[7] |=> user_output_port == $past(in_byte[6:0]);
    endproperty
    a_port: assert property (p_port) else $error("user port not latched"); // see RQ16

    property p_key;
        s_key_last |=> s_key_report ##0 (key_parity_error == parity_bad);
    endproperty
    a_key: assert property (p_key) else $error("key result not reported after completion"); // see RQ9

    property p_sync;
        sync_out |=> !sync_out ##14 sync_out;
    endproperty
    a_sync: assert property (p_sync) else $error("sync period not fifteen cycles"); // see RQ20
endmodule

// File: dv/bcu_host_model.sv
`timescale 1ns/100ps
module bcu_host_model (
    input  wire logic       core_clk,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic            register_select,
    output logic            dma_acknowledge_n,
    output logic      [7:0] d_in
);
    logic [7:0] exp_q[$];

    // ------------------------------------------------------------
    // bus master cycles
    // ------------------------------------------------------------
    // idle levels from time zero
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        register_select = 1'b0;
        dma_acknowledge_n = 1'b1;
        d_in = 8'h00;
    end

    // how: 0 nobody selected, 1 chip select, 2 dma acknowledge
    task automatic access(input logic [1:0] how, input logic is_rd, input logic a0, input logic [7:0] data);
        @(posedge core_clk);
        cs_n <= (how != 2'h1);
        dma_acknowledge_n <= (how != 2'h2);
        register_select <= a0;
        d_in <= data;
        if (is_rd) exp_q.push_back(data);
        @(posedge core_clk);
        rd_n <= !is_rd;
        wr_n <= is_rd;
        repeat (6) @(posedge core_clk);
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        cs_n <= 1'b1;
        dma_acknowledge_n <= 1'b1;
        d_in <= ~data;                       // released bus shows no stale byte
        repeat (8) @(posedge core_clk);      // input full gone before next write
    endtask
endmodule

// File: dv/block_cipher_host_port_bench.sv
`timescale 1ns/100ps
module block_cipher_host_port_bench;
    localparam int CONV = 2;
    logic       core_clk, srst, cs_n, rd_n, wr_n, register_select, dma_acknowledge_n, d_oe, oe_q;
    logic       service_request, output_available, conversion_complete, dma_request, sync_out;
    logic [7:0] d_in, d_out, port;
    logic [6:0] user_output_port;
    logic [7:0] key [8];
    logic [7:0] blk [8];
    int         mismatches = 0;
    int         n_compared = 0;
    int         seed = 32'h4b84_80c5;
    int         n;

    bcu_top #(.CONV_CYCLES(CONV)) bcu_top_i (.core_clk(core_clk), .srst(srst), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .register_select(register_select), .dma_acknowledge_n(dma_acknowledge_n), .d_in(d_in),
        .d_out(d_out), .d_oe(d_oe), .service_request(service_request), .output_available(output_available),
        .conversion_complete(conversion_complete), .dma_request(dma_request),
        .user_output_port(user_output_port), .sync_out(sync_out));
    bcu_host_model host_i (.core_clk(core_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .register_select(register_select), .dma_acknowledge_n(dma_acknowledge_n), .d_in(d_in));

    // clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] expect_v);
        n_compared++;
        if (seen !== expect_v) begin
            mismatches++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, expect_v);
        end
    endtask

    task automatic complete_run;
        if (host_i.exp_q.size() != 0) mismatches++;
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // each read answer against the oldest noted value
    always @(posedge core_clk) begin
        oe_q <= d_oe;
        if (d_oe === 1'b1 && oe_q !== 1'b1) check(d_out, host_i.exp_q.size() ? host_i.exp_q.pop_front() : 8'hxx);
    end

    task automatic wait_req;
        n = 0;
        while (dma_request !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 400) begin
            check({7'h00, dma_request}, 8'h01);
            complete_run();
        end
    endtask

    task automatic load_key(input logic bad);
        logic [7:0] b;
        host_i.access(2'h1, 1'b0, bcu_pkg::REG_CMD, bcu_pkg::OP_KEY);
        for (int i = 0; i < 8; i++) begin
            b = 8'($random(seed));
            b[0] = ~^b[7:1] ^ (bad && i == 3);   // odd parity, one spoiled byte when bad
            if (!bad) key[i] = b;
            host_i.access(2'h1, 1'b0, bcu_pkg::REG_DATA, b);
        end
    endtask

    // eight writes, then eight reads of data xor key
    task automatic convert(input logic dma);
        for (int i = 0; i < 8; i++) begin
            blk[i] = 8'($random(seed));
            if (dma) wait_req();
            host_i.access(dma ? 2'h2 : 2'h1, 1'b0, bcu_pkg::REG_DATA, blk[i]);
        end
        if (!dma) begin
            repeat (CONV + 12) @(posedge core_clk);
            check({6'h00, output_available, conversion_complete}, 8'h03);
            host_i.access(2'h1, 1'b1, bcu_pkg::REG_CMD, 8'h09);
        end
        for (int i = 0; i < 8; i++) begin
            if (dma) wait_req();
            host_i.access(dma ? 2'h2 : 2'h1, 1'b1, bcu_pkg::REG_DATA, blk[i] ^ key[i]);
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        check({1'b0, user_output_port}, 8'h7f);
        host_i.access(2'h1, 1'b1, bcu_pkg::REG_CMD, 8'h00);
        port = 8'($random(seed));
        host_i.access(2'h1, 1'b0, bcu_pkg::REG_CMD, {1'b1, port[6:0]});
        check({1'b0, user_output_port}, {1'b0, port[6:0]});
        host_i.access(2'h0, 1'b0, bcu_pkg::REG_CMD, 8'h80);
        check({1'b0, user_output_port}, {1'b0, port[6:0]});
        host_i.access(2'h1, 1'b0, bcu_pkg::REG_CMD, 8'h0d);
        check({7'h00, service_request}, 8'h01);
        load_key(1'b0);
        host_i.access(2'h1, 1'b1, bcu_pkg::REG_CMD, 8'h00);
        host_i.access(2'h1, 1'b0, bcu_pkg::REG_CMD, bcu_pkg::OP_DEC);
        host_i.access(2'h1, 1'b1, bcu_pkg::REG_CMD, 8'h04);
        host_i.access(2'h1, 1'b0, bcu_pkg::REG_CMD, bcu_pkg::OP_ENC);
        host_i.access(2'h1, 1'b1, bcu_pkg::REG_CMD, 8'h00);
        convert(1'b0);
        check({7'h00, conversion_complete}, 8'h00);
        host_i.access(2'h1, 1'b1, bcu_pkg::REG_CMD, 8'h00);
        host_i.access(2'h1, 1'b0, bcu_pkg::REG_CMD, 8'h0f);
        host_i.access(2'h1, 1'b0, bcu_pkg::REG_DATA, 8'h01);
        convert(1'b1);
        repeat (CONV + 12) @(posedge core_clk);
        check({7'h00, conversion_complete}, 8'h01);
        host_i.access(2'h1, 1'b1, bcu_pkg::REG_CMD, 8'h08);
        load_key(1'b1);
        host_i.access(2'h1, 1'b1, bcu_pkg::REG_CMD, 8'h10);
        n = 0;
        repeat (150) begin
            @(posedge core_clk);
            if (sync_out === 1'b1) n++;
        end
        check(n[7:0], 8'h0a);
        complete_run();
    end
endmodule
